// file: design/evts_queue.sv
// eight-entry first-in first-out queue of captured event stamps
`timescale 1ns/1ps
module evts_queue
   import evts_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // fill side
   input wire logic push,
   input event_entry_t push_data,
   // drain side
   input wire logic pop,
   output event_entry_t head,
   output logic not_empty,
   output logic full
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
   end
   event_entry_t mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire do_push = push && !full;
   wire do_pop = pop && not_empty;
   // status from pointers
   assign not_empty = wr_ptr != rd_ptr;
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign head = mem[rd_ptr[AW-1:0]];
   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (do_push) mem[wr_ptr[AW-1:0]] <= push_data;
   end
   // pointers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + 1'b1;
         if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : evts_queue

// file: design/evts_unit.sv
// event timestamp unit: pin edge capture, stamp queue, interrupt routing
`timescale 1ns/1ps
module evts_unit
   import evts_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS,
   parameter int PINS = NUM_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // precision clock time
   input ptp_time_t ptp_time,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // general-purpose pins
   input wire logic [PINS-1:0] gpio_in,
   output logic [PINS-1:0] gpio_out,
   output logic [PINS-1:0] gpio_oe_n,
   // other phy interrupt sources and shared pin
   input wire logic phy_irq,
   output logic powerdown_interrupt_pin_n
);
   initial begin
      if (CHANNELS != NUM_CHANNELS) $error("channel count fixed at eight");
      if (PINS != NUM_PINS || PINS > 16) $error("pin count fixed at twelve");
   end

   // pin number of a channel from the select words
   function automatic logic [3:0] pin_of(input logic [63:0] sel, input int ch);
      pin_of = sel[ch*4 +: 4];
   endfunction : pin_of

   // software-visible registers
   logic [31:0] event_config_register;
   logic [63:0] pin_select;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic irq_route_gpio;
   logic [3:0] irq_pin;
   logic [MISS_W-1:0] miss_count;

   // pin synchronisers and edge history
   logic [PINS-1:0] sync_a;
   logic [PINS-1:0] sync_b;
   logic [PINS-1:0] pin_prev;

   // two flip-flops before any logic sees a pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_a <= '0;
         sync_b <= '0;
         pin_prev <= '0;
      end else begin
         sync_a <= gpio_in;
         sync_b <= sync_a;
         pin_prev <= sync_b;
      end
   end

   // per-channel edge detect on its selected pin
   logic [CHANNELS-1:0] ch_rise;
   logic [CHANNELS-1:0] ch_fall;
   logic [CHANNELS-1:0] ch_hit;
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         ch_rise[c] = sync_b[pin_of(pin_select, c)] && !pin_prev[pin_of(pin_select, c)];
         ch_fall[c] = !sync_b[pin_of(pin_select, c)] && pin_prev[pin_of(pin_select, c)];
         ch_hit[c] = event_config_register[CFG_EN_LSB + c] &&
            ((ch_rise[c] && event_config_register[CFG_RISE_LSB + c]) ||
             (ch_fall[c] && event_config_register[CFG_FALL_LSB + c]));
      end
   end

   // lowest-numbered channel wins a same-cycle tie
   logic [2:0] win_ch;
   logic any_hit;
   logic [3:0] hit_count;
   always_comb begin
      win_ch = '0;
      any_hit = 1'b0;
      hit_count = '0;
      for (int c = CHANNELS - 1; c >= 0; c--) begin
         if (ch_hit[c]) begin
            win_ch = 3'(c);
            any_hit = 1'b1;
            hit_count = hit_count + 4'h1;
         end
      end
   end

   // queue of stamps
   event_entry_t push_data;
   event_entry_t head;
   logic not_empty;
   logic full;
   wire pop = rd && (addr == ADDR_TS_SEC) && not_empty;
   wire accept = any_hit && !full;
   wire [3:0] extra = hit_count - 4'h1;
   wire [4:0] lost_now = full ? {1'b0, hit_count} : {1'b0, extra};
   wire [4:0] miss_sum = {1'b0, miss_count} + lost_now;
   wire [MISS_W-1:0] miss_sat = miss_sum[4] ? {MISS_W{1'b1}} : miss_sum[MISS_W-1:0];

   // entry carries the time sampled in the capture cycle
   assign push_data.stamp = ptp_time;
   assign push_data.channel = win_ch;
   assign push_data.rising = ch_rise[win_ch];
   assign push_data.missed = miss_sat;

   evts_queue #(
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .nrst(nrst),
      .push(accept),
      .push_data(push_data),
      .pop(pop),
      .head(head),
      .not_empty(not_empty),
      .full(full)
   );

   // missed events since last stored entry
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         miss_count <= '0;
      end else if (accept) begin
         miss_count <= '0;
      end else if (any_hit) begin
         miss_count <= miss_sat;
      end
   end

   // register decode
   wire wr_cfg = wr && addr == ADDR_CFG;
   wire wr_lo = wr && addr == ADDR_PINSEL_LO;
   wire wr_hi = wr && addr == ADDR_PINSEL_HI;
   wire wr_irq_clr = wr && addr == ADDR_IRQ_STATUS;
   wire wr_mask = wr && addr == ADDR_IRQ_MASK;
   wire wr_route = wr && addr == ADDR_IRQ_ROUTE;

   // control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         event_config_register <= CFG_RESET;
         pin_select <= '0;
         irq_mask <= MASK_RESET[1:0];
         irq_route_gpio <= 1'b0;
         irq_pin <= '0;
      end else begin
         if (wr_cfg) event_config_register <= {8'h00, wdata[23:0]};
         if (wr_lo) pin_select[31:0] <= wdata;
         if (wr_hi) pin_select[63:32] <= wdata;
         if (wr_mask) irq_mask <= wdata[1:0];
         if (wr_route) irq_route_gpio <= wdata[ROUTE_GPIO_BIT];
         if (wr_route) irq_pin <= wdata[ROUTE_PIN_LSB +: 4];
      end
   end

   // sticky interrupt causes: set wins over write-one clear
   wire [1:0] irq_set = {any_hit && (full || extra != 4'h0), accept};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~(wr_irq_clr ? wdata[1:0] : 2'b00)) | irq_set;
      end
   end

   // read mux
   logic [31:0] next_rdata;
   wire [31:0] est_word = {23'h0, not_empty, head.missed, head.rising, head.channel};
   always_comb begin
      case (addr)
         ADDR_CFG: next_rdata = event_config_register;
         ADDR_PINSEL_LO: next_rdata = pin_select[31:0];
         ADDR_PINSEL_HI: next_rdata = pin_select[63:32];
         ADDR_PTP_STATUS: next_rdata = {31'h0, not_empty};
         ADDR_EVENT_STATUS: next_rdata = not_empty ? est_word : 32'h0000_0000;
         ADDR_TS_NS: next_rdata = {2'b00, head.stamp.ns};
         ADDR_TS_SEC: next_rdata = head.stamp.sec;
         ADDR_IRQ_STATUS: next_rdata = {30'h0, irq_status};
         ADDR_IRQ_MASK: next_rdata = {30'h0, irq_mask};
         ADDR_IRQ_ROUTE: next_rdata = {27'h0, irq_pin, irq_route_gpio};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // read data stands the cycle after the strobe only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? next_rdata : 32'h0000_0000;
      end
   end

   // interrupt level and routing
   wire irq_level = |(irq_status & irq_mask);
   logic gpio_irq;
   logic shared_irq;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_irq <= 1'b0;
         shared_irq <= 1'b0;
      end else begin
         gpio_irq <= irq_route_gpio && irq_level;
         shared_irq <= (!irq_route_gpio && irq_level) || phy_irq;
      end
   end
   assign powerdown_interrupt_pin_n = !shared_irq;

   // gpio driven only as interrupt output when so routed
   always_comb begin
      for (int p = 0; p < PINS; p++) begin
         gpio_out[p] = gpio_irq;
         gpio_oe_n[p] = !(irq_route_gpio && irq_pin == 4'(p));
      end
   end
endmodule : evts_unit

// file: pkg/evts_pkg.sv
// package of constants and types for the event timestamp unit
package evts_pkg;
   // register word offsets on the plain register port (byte addresses)
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_PINSEL_LO = 8'h04;
   localparam logic [7:0] ADDR_PTP_STATUS = 8'h08;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_TS_NS = 8'h10;
   localparam logic [7:0] ADDR_TS_SEC = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_ROUTE = 8'h20;
   localparam logic [7:0] ADDR_PINSEL_HI = 8'h24;
   // counts
   localparam int NUM_CHANNELS = 8;
   localparam int NUM_PINS = 12;
   localparam int QUEUE_DEPTH = 8;
   localparam int SEC_W = 32;
   localparam int NS_W = 30;
   localparam int MISS_W = 4;
   // event config register: [7:0] enable, [15:8] rise, [23:16] fall
   localparam int CFG_EN_LSB = 0;
   localparam int CFG_RISE_LSB = 8;
   localparam int CFG_FALL_LSB = 16;
   // event status fields: [2:0] channel, [3] rising, [7:4] missed, [8] valid
   localparam int EST_CH_LSB = 0;
   localparam int EST_RISE_BIT = 3;
   localparam int EST_MISS_LSB = 4;
   localparam int EST_VALID_BIT = 8;
   // irq route: [0] use gpio, [4:1] gpio number
   localparam int ROUTE_GPIO_BIT = 0;
   localparam int ROUTE_PIN_LSB = 1;
   // interrupt status bits
   localparam int IRQ_READY_BIT = 0;
   localparam int IRQ_OVF_BIT = 1;
   // reset values
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   // input path delay that software subtracts from each stamp
   localparam int CORR_NS = 35;
   // one precision-clock time value
   typedef struct packed {
      logic [SEC_W-1:0] sec;
      logic [NS_W-1:0] ns;
   } ptp_time_t;
   // one queued event
   typedef struct packed {
      ptp_time_t stamp;
      logic [2:0] channel;
      logic rising;
      logic [MISS_W-1:0] missed;
   } event_entry_t;
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : evts_pkg

// file: tb/evts_pin_src.sv
// outside devices that drive the event pins
`timescale 1ns/1ps
module evts_pin_src (
   // levels asked for by the bench
   input wire logic [11:0] want,
   // levels on the pins
   output logic [11:0] gpio_in
);
   // pins move 37 ns after the bench level changes, away from clock edges
   assign #37 gpio_in = want;
endmodule : evts_pin_src

// file: tb/evts_unit_asserts.sv
// port checker for the event timestamp unit
`timescale 1ns/1ps
module evts_unit_asserts
   import evts_pkg::*;
#(
   parameter int PINS = NUM_PINS
) (
   // clock, reset and read port
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // interrupt pins
   input wire logic [PINS-1:0] gpio_out,
   input wire logic [PINS-1:0] gpio_oe_n,
   input wire logic phy_irq,
   input wire logic powerdown_interrupt_pin_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // read data only in the cycle after a read, field widths exact
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data without a read");
   AST_READY_BIT: assert property (rd && addr == ADDR_PTP_STATUS |=> rdata[31:1] == 31'h0)
      else $error("ready word has stray bits");
   AST_STATUS_TOP: assert property (rd && addr == ADDR_EVENT_STATUS |=> rdata[31:9] == 23'h0)
      else $error("event status has stray bits");
   AST_NS_WIDTH: assert property (rd && addr == ADDR_TS_NS |=> rdata[31:30] == 2'h0)
      else $error("nanoseconds wider than 30 bits");
   // interrupt routing: one pin at most, shared pin keeps other sources
   AST_OE_ONE: assert property ($countones(~gpio_oe_n) <= 1)
      else $error("more than one interrupt pin driven");
   AST_OUT_SAME: assert property (gpio_out == {PINS{gpio_out[0]}})
      else $error("gpio outputs disagree");
   AST_PHY_OR: assert property (phy_irq |=> !powerdown_interrupt_pin_n)
      else $error("phy interrupt not passed to shared pin");
   AST_ROUTE_SPLIT: assert property (!(&gpio_oe_n) && $past(!(&gpio_oe_n)) && !$past(phy_irq)
      |-> powerdown_interrupt_pin_n)
      else $error("routed interrupt leaks to shared pin");
   C_POP: cover property (rd && addr == ADDR_TS_SEC);
   C_ROUTED: cover property (!(&gpio_oe_n) && gpio_out[0]);
   C_PHY: cover property (phy_irq ##1 !powerdown_interrupt_pin_n);
endmodule : evts_unit_asserts
bind evts_unit evts_unit_asserts #(.PINS(PINS)) u_chk (.clk(clk), .nrst(nrst), .addr(addr),
   .rd(rd), .rdata(rdata), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .phy_irq(phy_irq),
   .powerdown_interrupt_pin_n(powerdown_interrupt_pin_n));

// file: tb/tb_evts_unit.sv
// self-checking bench for the event timestamp unit
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_evts_unit
   import evts_pkg::*;
();
   logic clk, nrst, wr, rd, phy_irq, pin_n;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [11:0] want, gpio_in, gpio_out, gpio_oe_n;
   ptp_time_t ptp_time;
   logic [29:0] exp_ns[$];
   int fail_count, total_checks, cyc, i;
   evts_pin_src src (.want(want), .gpio_in(gpio_in));
   evts_unit dut (.clk(clk), .nrst(nrst), .ptp_time(ptp_time), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .phy_irq(phy_irq), .powerdown_interrupt_pin_n(pin_n));
   // clock, time counter and hang limit
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      ptp_time.ns <= ptp_time.ns + 30'h1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   // one pin change; two sync flops and the edge history put the capture two ticks on
   task automatic pin(input int p, input logic v, input logic keep);
      @(posedge clk);
      want[p] <= v;
      #1 if (keep) exp_ns.push_back(ptp_time.ns + 30'h2);
      repeat (4) @(posedge clk);
   endtask : pin
   task automatic pop(input logic [8:0] st);
      logic [29:0] e;
      e = exp_ns.pop_front();
      rreg(ADDR_EVENT_STATUS);
      `CHK(d[8:0], st)
      rreg(ADDR_TS_NS);
      `CHK(d[29:0], e)
      rreg(ADDR_TS_SEC);
      `CHK(d, 32'hA5A5_0001)
   endtask : pop
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // rise on ch0/pin3, fall on ch1/pin7, both on ch2/pin11
   task automatic t_edges();
      wreg(ADDR_PINSEL_LO, 32'h0000_0B73);
      wreg(ADDR_CFG, 32'h0006_0507);
      pin(3, 1'b1, 1'b1);
      pin(3, 1'b0, 1'b0);
      pin(7, 1'b1, 1'b0);
      pin(7, 1'b0, 1'b1);
      pin(11, 1'b1, 1'b1);
      pin(11, 1'b0, 1'b1);
      rreg(ADDR_PTP_STATUS);
      `CHK(d[0], 1'b1)
      pop(9'h108);
      pop(9'h101);
      pop(9'h10A);
      pop(9'h102);
      rreg(ADDR_PTP_STATUS);
      `CHK(d[0], 1'b0)
   endtask : t_edges
   // ten edges into eight places, then the misses ride on the next entry
   task automatic t_ovf();
      wreg(ADDR_CFG, 32'h0001_0101);
      for (i = 0; i < 10; i++) pin(3, ~want[3], logic'(i < 8));
      rreg(ADDR_IRQ_STATUS);
      `CHK(d[1:0], 2'h3)
      for (i = 0; i < 8; i++) pop(i % 2 ? 9'h100 : 9'h108);
      rreg(ADDR_EVENT_STATUS);
      `CHK(d[8:0], 9'h000)
      pin(3, 1'b1, 1'b1);
      pop(9'h128);
   endtask : t_ovf
   // mask, shared pin, gpio routing, other phy sources, unmapped place
   task automatic t_irq();
      wreg(ADDR_IRQ_STATUS, 32'h0000_0003);
      rreg(ADDR_IRQ_STATUS);
      `CHK(d[1:0], 2'h0)
      pin(3, 1'b0, 1'b1);
      `CHK(pin_n, 1'b1)
      wreg(ADDR_IRQ_MASK, 32'h0000_0001);
      settle();
      `CHK(pin_n, 1'b0)
      wreg(ADDR_IRQ_ROUTE, 32'h0000_000B);
      settle();
      `CHK({gpio_oe_n, gpio_out[5], pin_n}, {12'hFDF, 2'h3})
      pop(9'h100);
      wreg(ADDR_IRQ_STATUS, 32'h0000_0001);
      settle();
      `CHK(gpio_out[5], 1'b0)
      wreg(ADDR_IRQ_ROUTE, 32'h0000_0000);
      phy_irq <= 1'b1;
      settle();
      `CHK({gpio_oe_n, pin_n}, 13'h1FFE)
      phy_irq <= 1'b0;
      wreg(8'h30, 32'hFFFF_FFFF);
      rreg(8'h30);
      `CHK(d, 32'h0000_0000)
   endtask : t_irq
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // reset, then the scenarios
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      want = 12'h000;
      phy_irq = 1'b0;
      ptp_time = {32'hA5A5_0001, 30'h0};
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_edges();
      t_ovf();
      t_irq();
      end_sim();
   end
endmodule : tb_evts_unit
